// ===== verilog/io_line_pkg.sv
package io_line_pkg;

   // ***********************************************
   // Register offsets (byte addresses)
   // ***********************************************
   localparam logic [7:0] OFF_LINE_CTRL_ENABLE    = 8'h00;
   localparam logic [7:0] OFF_LINE_CTRL_DISABLE   = 8'h04;
   localparam logic [7:0] OFF_LINE_CTRL_STATUS    = 8'h08;
   localparam logic [7:0] OFF_DRIVE_ENABLE        = 8'h10;
   localparam logic [7:0] OFF_DRIVE_DISABLE       = 8'h14;
   localparam logic [7:0] OFF_DRIVE_STATUS        = 8'h18;
   localparam logic [7:0] OFF_FILTER_ENABLE       = 8'h20;
   localparam logic [7:0] OFF_FILTER_DISABLE      = 8'h24;
   localparam logic [7:0] OFF_FILTER_STATUS       = 8'h28;
   localparam logic [7:0] OFF_LEVEL_SET           = 8'h30;
   localparam logic [7:0] OFF_LEVEL_CLEAR         = 8'h34;
   localparam logic [7:0] OFF_DRIVEN_LEVEL_STATUS = 8'h38;
   localparam logic [7:0] OFF_PIN_LEVEL           = 8'h3c;
   localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE   = 8'h40;
   localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE  = 8'h44;
   localparam logic [7:0] OFF_CHANGE_IRQ_MASK     = 8'h48;
   localparam logic [7:0] OFF_CHANGE_IRQ_STATUS   = 8'h4c;
   localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE   = 8'h50;
   localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE  = 8'h54;
   localparam logic [7:0] OFF_OPEN_DRAIN_STATUS   = 8'h58;
   localparam logic [7:0] OFF_PULLUP_DISABLE      = 8'h60;
   localparam logic [7:0] OFF_PULLUP_ENABLE       = 8'h64;
   localparam logic [7:0] OFF_PULLUP_STATUS       = 8'h68;
   localparam logic [7:0] OFF_DIRECT_WRITE_ENABLE = 8'ha0;
   localparam logic [7:0] OFF_DIRECT_WRITE_DISABLE = 8'ha4;
   localparam logic [7:0] OFF_DIRECT_WRITE_STATUS = 8'ha8;

   // ***********************************************
   // Line population and reset values
   // ***********************************************
   localparam logic [31:0] LINE_MASK   = 32'h0fff_ffff; // Lines built
   localparam logic [31:0] MUXED_MASK  = 32'h0fff_0000; // Lines with periph
   localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic [31:0] line_ctrl;
      logic [31:0] drive;
      logic [31:0] filter;
      logic [31:0] level;
      logic [31:0] irq_mask;
      logic [31:0] irq_status;
      logic [31:0] open_drain;
      logic [31:0] pullup_off;
      logic [31:0] direct_write;
   } regs_t;

   typedef struct packed {
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic [31:0] filt;
   } filt_state_t;

endpackage : io_line_pkg

// ===== verilog/line_sampler.sv
`timescale 1ns/1ns
module line_sampler (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic [31:0] filter_on,
   input  wire logic [31:0] pad_in,
   output logic      [31:0] raw_sync,
   output logic      [31:0] level
);

   io_line_pkg::filt_state_t s_q;
   io_line_pkg::filt_state_t s_d;

   // ***********************************************
   // Synchroniser and glitch filter
   // ***********************************************
   // Sync stage always runs so peripherals see pins with the clock gated
   always_comb begin
      s_d       = s_q;
      s_d.sync1 = pad_in;
      s_d.sync2 = s_q.sync1;
      if (clk_en) begin
         // Every sampled level passes one cycle late; a glitch between
         // two edges is never sampled, one spanning an edge gets through
         s_d.filt = s_q.sync2;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Peripherals take the unfiltered input
   assign raw_sync = s_q.sync2;
   assign level    = (filter_on & s_q.filt) | (~filter_on & s_q.sync2);

endmodule : line_sampler

// ===== verilog/io_line_ctrl.sv
`timescale 1ns/1ns
module io_line_ctrl (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ctrl_clk_en,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Lines
   input  wire logic [31:0] pad_in,
   output logic      [31:0] pad_out,
   output logic      [31:0] pad_oe,
   output logic      [31:0] pullup_on,
   input  wire logic [31:0] periph_out,
   input  wire logic [31:0] periph_oe,
   output logic      [31:0] periph_in,
   output logic             change_irq
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      io_line_pkg::regs_t r;
      logic [31:0] pin;        // Frozen readback sample
      logic [31:0] prev;       // Previous sample for change detect
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] pad_out;
      logic [31:0] pad_oe;
      logic [31:0] pullup_on;
      logic [31:0] periph_in;
      logic        irq;
   } state_t;

   state_t st_q;
   state_t st_d;

   logic [31:0] raw_sync;
   logic [31:0] line_level;

   // ***********************************************
   // Functions
   // ***********************************************
   // Byte strobes widened to a bit mask, limited to built lines
   function automatic logic [31:0] strb_bits(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m & io_line_pkg::LINE_MASK;
   endfunction : strb_bits

   // Set/clear pair acting on one status word
   function automatic logic [31:0] set_clr(input logic [31:0] cur,
                                           input logic [31:0] set,
                                           input logic [31:0] clr);
      return (cur | set) & ~clr;
   endfunction : set_clr

   // Map an offset onto the implemented register set, all but OFF_CHANGE_IRQ_STATUS (0x4c)
   function automatic logic known_addr(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      if (a[1:0] == 2'h0) begin
         if (a <= io_line_pkg::OFF_PULLUP_STATUS) begin
            ok = (a[3:2] != 2'h3) || (a[7:4] == 4'h3);
         end
         if ((a >= io_line_pkg::OFF_DIRECT_WRITE_ENABLE) &&
             (a <= io_line_pkg::OFF_DIRECT_WRITE_STATUS)) begin
            ok = 1'b1;
         end
      end
      return ok;
   endfunction : known_addr

   // ***********************************************
   // Input path
   // ***********************************************
   line_sampler u_sampler (
      .clk       (clk),
      .resetn    (resetn),
      .clk_en    (ctrl_clk_en),
      .filter_on (st_q.r.filter),
      .pad_in    (pad_in),
      .raw_sync  (raw_sync),
      .level     (line_level)
   );

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      logic        do_write;
      logic        do_read;
      logic [31:0] wm;
      logic [31:0] wv;
      logic [31:0] change;
      logic [31:0] rd;
      logic [31:0] drv_level;
      logic [31:0] drv_en;
      do_write  = 1'b0;
      do_read   = 1'b0;
      wm        = '0;
      wv        = '0;
      change    = '0;
      rd        = '0;
      drv_level = '0;
      drv_en    = '0;
      st_d      = st_q;

      // Sampling and change detection need the controller clock
      if (ctrl_clk_en) begin
         st_d.pin  = line_level;
         st_d.prev = line_level;
         change    = (line_level ^ st_q.prev)
                     & io_line_pkg::LINE_MASK;
      end

      // Write channels taken independently, in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;
      wm = strb_bits(st_q.wstrb);
      wv = st_q.wdata & wm;

      if (do_write) begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = known_addr(st_q.awaddr) ? io_line_pkg::RESP_OKAY
                                               : io_line_pkg::RESP_SLVERR;
         unique case (st_q.awaddr)
            io_line_pkg::OFF_LINE_CTRL_ENABLE:
               st_d.r.line_ctrl = set_clr(st_q.r.line_ctrl, wv, '0);
            io_line_pkg::OFF_LINE_CTRL_DISABLE:
               st_d.r.line_ctrl = set_clr(st_q.r.line_ctrl, '0, wv);
            io_line_pkg::OFF_DRIVE_ENABLE:
               st_d.r.drive = set_clr(st_q.r.drive, wv, '0);
            io_line_pkg::OFF_DRIVE_DISABLE:
               st_d.r.drive = set_clr(st_q.r.drive, '0, wv);
            io_line_pkg::OFF_FILTER_ENABLE:
               st_d.r.filter = set_clr(st_q.r.filter, wv, '0);
            io_line_pkg::OFF_FILTER_DISABLE:
               st_d.r.filter = set_clr(st_q.r.filter, '0, wv);
            io_line_pkg::OFF_LEVEL_SET:
               st_d.r.level = set_clr(st_q.r.level, wv, '0);
            io_line_pkg::OFF_LEVEL_CLEAR:
               st_d.r.level = set_clr(st_q.r.level, '0, wv);
            io_line_pkg::OFF_DRIVEN_LEVEL_STATUS: begin
               // Only bits opened by the direct-write mask move
               wm = wm & st_q.r.direct_write;
               st_d.r.level = (st_q.r.level & ~wm) | (st_q.wdata & wm);
            end
            io_line_pkg::OFF_CHANGE_IRQ_ENABLE:
               st_d.r.irq_mask = set_clr(st_q.r.irq_mask, wv, '0);
            io_line_pkg::OFF_CHANGE_IRQ_DISABLE:
               st_d.r.irq_mask = set_clr(st_q.r.irq_mask, '0, wv);
            io_line_pkg::OFF_OPEN_DRAIN_ENABLE:
               st_d.r.open_drain = set_clr(st_q.r.open_drain, wv, '0);
            io_line_pkg::OFF_OPEN_DRAIN_DISABLE:
               st_d.r.open_drain = set_clr(st_q.r.open_drain, '0, wv);
            io_line_pkg::OFF_PULLUP_DISABLE:
               st_d.r.pullup_off = set_clr(st_q.r.pullup_off, wv, '0);
            io_line_pkg::OFF_PULLUP_ENABLE:
               st_d.r.pullup_off = set_clr(st_q.r.pullup_off, '0, wv);
            io_line_pkg::OFF_DIRECT_WRITE_ENABLE:
               st_d.r.direct_write = set_clr(st_q.r.direct_write, wv, '0);
            io_line_pkg::OFF_DIRECT_WRITE_DISABLE:
               st_d.r.direct_write = set_clr(st_q.r.direct_write, '0, wv);
            default: ;
         endcase
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // Read decode, built lines only
      unique case (s_axi_araddr)
         io_line_pkg::OFF_LINE_CTRL_STATUS:
            rd = st_q.r.line_ctrl | ~io_line_pkg::MUXED_MASK;
         io_line_pkg::OFF_DRIVE_STATUS:        rd = st_q.r.drive;
         io_line_pkg::OFF_FILTER_STATUS:       rd = st_q.r.filter;
         io_line_pkg::OFF_DRIVEN_LEVEL_STATUS: rd = st_q.r.level;
         io_line_pkg::OFF_PIN_LEVEL:           rd = st_q.pin;
         io_line_pkg::OFF_CHANGE_IRQ_MASK:     rd = st_q.r.irq_mask;
         io_line_pkg::OFF_CHANGE_IRQ_STATUS:   rd = st_q.r.irq_status;
         io_line_pkg::OFF_OPEN_DRAIN_STATUS:   rd = st_q.r.open_drain;
         io_line_pkg::OFF_PULLUP_STATUS:       rd = st_q.r.pullup_off;
         io_line_pkg::OFF_DIRECT_WRITE_STATUS: rd = st_q.r.direct_write;
         default:                              rd = '0;
      endcase
      do_read = s_axi_arvalid && st_q.arready;
      if (do_read) begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = rd & io_line_pkg::LINE_MASK;
         st_d.rresp  = known_addr(s_axi_araddr) ? io_line_pkg::RESP_OKAY
                                                : io_line_pkg::RESP_SLVERR;
      end else if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end

      // Clearing read loses no change: set beats clear
      if (do_read && (s_axi_araddr == io_line_pkg::OFF_CHANGE_IRQ_STATUS))
      begin
         st_d.r.irq_status = change;
      end else begin
         st_d.r.irq_status = st_q.r.irq_status | change;
      end

      // Ready flags registered so every bus output is a flop
      st_d.awready = !st_d.aw_got && !st_d.bvalid;
      st_d.wready  = !st_d.w_got && !st_d.bvalid;
      st_d.arready = !st_d.rvalid;

      // Pad drive: peripheral when it owns the line, else controller
      drv_level = (st_d.r.line_ctrl | ~io_line_pkg::MUXED_MASK);
      drv_en    = (drv_level & st_d.r.drive) | (~drv_level & periph_oe);
      drv_level = (drv_level & st_d.r.level) | (~drv_level & periph_out);
      // Open drain only pulls low
      st_d.pad_oe    = drv_en & ~(st_d.r.open_drain & drv_level)
                       & io_line_pkg::LINE_MASK;
      st_d.pad_out   = drv_level & ~st_d.r.open_drain;
      st_d.pullup_on = ~st_d.r.pullup_off & io_line_pkg::LINE_MASK;
      st_d.periph_in = raw_sync;
      // One ORed request for all lines
      st_d.irq = |(st_d.r.irq_status & st_d.r.irq_mask);
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q           <= '0;
         st_q.awready   <= 1'b1;
         st_q.wready    <= 1'b1;
         st_q.arready   <= 1'b1;
         st_q.pullup_on <= io_line_pkg::LINE_MASK;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready  = st_q.wready;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = st_q.rresp;
   assign pad_out       = st_q.pad_out;
   assign pad_oe        = st_q.pad_oe;
   assign pullup_on     = st_q.pullup_on;
   assign periph_in     = st_q.periph_in;
   assign change_irq    = st_q.irq;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_wr(logic [7:0] a);
      st_q.aw_got && st_q.w_got && !st_q.bvalid && st_q.awaddr == a;
   endsequence

   a_direct_write_mask: assert property (
      s_wr(io_line_pkg::OFF_DRIVEN_LEVEL_STATUS) |=>
      ((st_q.r.level ^ $past(st_q.r.level)) & ~$past(st_q.r.direct_write))
      == '0)
      else $error("direct write moved a masked line");
   a_pin_freeze: assert property (
      !ctrl_clk_en |=> st_q.pin == $past(st_q.pin))
      else $error("pin level moved with clock off");
   a_filter_set: assert property (
      s_wr(io_line_pkg::OFF_FILTER_ENABLE) |=>
      (st_q.r.filter & $past(strb_bits(st_q.wstrb) & st_q.wdata))
      == $past(strb_bits(st_q.wstrb) & st_q.wdata))
      else $error("filter enable did not set status");
   a_mask_clear: assert property (
      s_wr(io_line_pkg::OFF_CHANGE_IRQ_DISABLE) |=>
      (st_q.r.irq_mask & $past(strb_bits(st_q.wstrb) & st_q.wdata)) == '0)
      else $error("irq disable did not clear mask");
   a_change_sets: assert property (
      ctrl_clk_en && ((line_level ^ st_q.prev) != '0) |=>
      (st_q.r.irq_status & $past((line_level ^ st_q.prev)
      & io_line_pkg::LINE_MASK)) == $past((line_level ^ st_q.prev)
      & io_line_pkg::LINE_MASK))
      else $error("input change not recorded");
   a_irq_or: assert property (
      change_irq == |(st_q.r.irq_status & st_q.r.irq_mask))
      else $error("interrupt output not OR of masked status");
   a_read_clears: assert property (
      s_axi_arvalid && s_axi_arready && !ctrl_clk_en &&
      s_axi_araddr == io_line_pkg::OFF_CHANGE_IRQ_STATUS
      |=> st_q.r.irq_status == '0 ##0 s_axi_rvalid)
      else $error("status read did not clear");
   a_unbuilt_zero: assert property (
      s_axi_rvalid |-> (s_axi_rdata & ~io_line_pkg::LINE_MASK) == '0)
      else $error("unbuilt line read nonzero");
   a_owner_one: assert property (
      s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == io_line_pkg::OFF_LINE_CTRL_STATUS) |->
      (s_axi_rdata & io_line_pkg::LINE_MASK & ~io_line_pkg::MUXED_MASK)
      == (io_line_pkg::LINE_MASK & ~io_line_pkg::MUXED_MASK))
      else $error("unmuxed line ownership not one");
   a_write_resp: assert property (
      s_wr(io_line_pkg::OFF_LEVEL_SET) |=> s_axi_bvalid)
      else $error("write response late");

endmodule : io_line_ctrl

// ===== testbench/line_partner.sv
`timescale 1ns/1ns
// ***********************************************
// Far side of the lines: external drivers and pads
// ***********************************************
module line_partner (
   input  wire logic        clk,
   input  wire logic [31:0] pad_out,
   input  wire logic [31:0] pad_oe,
   input  wire logic [31:0] pullup_on,
   input  wire logic [31:0] ext_val,
   input  wire logic [31:0] ext_oe,
   output logic      [31:0] pad_in
);
   logic [31:0] wander;
   // Floating lines flip each cycle, so a stale level never reads as valid
   initial begin
      wander = 32'h0000_0000;
      forever @(posedge clk) wander <= ~wander;
   end
   // Controller wins, then far side, then pull-up, else floating
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                 | (~pad_oe & ~ext_oe & (pullup_on | wander));
endmodule : line_partner

// ===== testbench/test_io_line_input_and_change_irq.sv
`timescale 1ns/1ns
module test_io_line_input_and_change_irq;
   logic        clk, resetn, ctrl_clk_en, change_irq;
   logic [7:0]  awaddr, araddr, base;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] wdata, rdata, ext_val, ext_oe, periph_out, periph_oe;
   logic [31:0] pad_in, pad_out, pad_oe, pullup_on, periph_in;
   logic [31:0] rd_v, lvl, d, m;
   logic [3:0]  strb;
   logic [7:0]  zero_a [6];
   int          failures, n_checks, seed;

   io_line_ctrl dut (.clk(clk), .resetn(resetn), .ctrl_clk_en(ctrl_clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .pullup_on(pullup_on), .periph_out(periph_out),
      .periph_oe(periph_oe), .periph_in(periph_in),
      .change_irq(change_irq));
   line_partner far (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pullup_on(pullup_on), .ext_val(ext_val), .ext_oe(ext_oe),
      .pad_in(pad_in));

   // ***********************************************
   // Clock, checks and bus cycles
   // ***********************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Masked merge of a direct level write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] v,
                                         input logic [31:0] k);
      return (old & ~k) | (v & k & io_line_pkg::LINE_MASK);
   endfunction : merge
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd_v = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic complete_run;
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      #100000;
      failures++;
      complete_run();
   end

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      seed = 32'h75d922e0;
      {failures, n_checks} = 0;
      {resetn, ctrl_clk_en, awvalid, wvalid, bready, arvalid, rready} = 0;
      {awaddr, araddr, wdata, ext_val, periph_out, periph_oe} = 0;
      ext_oe = 32'h0000_0300;
      strb = 4'hf;
      lvl = 32'h0000_0000;
      zero_a = '{io_line_pkg::OFF_DRIVE_STATUS, io_line_pkg::OFF_FILTER_STATUS,
         io_line_pkg::OFF_DRIVEN_LEVEL_STATUS, io_line_pkg::OFF_CHANGE_IRQ_MASK,
         io_line_pkg::OFF_OPEN_DRAIN_STATUS, io_line_pkg::OFF_DIRECT_WRITE_STATUS};
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      ctrl_clk_en <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(zero_a[i]);
         chk(rd_v, 32'h0000_0000);
      end
      // Reserved hole answers with an error and zero data
      rd(8'h0c);
      chk({rd_v[31:2], rsp}, {30'h0, io_line_pkg::RESP_SLVERR});
      wr(8'h0c, 32'hffff_ffff);
      chk({30'h0, rsp}, {30'h0, io_line_pkg::RESP_SLVERR});
      wr(io_line_pkg::OFF_LINE_CTRL_DISABLE, 32'hffff_ffff);
      rd(io_line_pkg::OFF_LINE_CTRL_STATUS);
      chk(rd_v, io_line_pkg::LINE_MASK & ~io_line_pkg::MUXED_MASK);
      wr(io_line_pkg::OFF_LINE_CTRL_ENABLE, 32'hffff_ffff);
      chk({30'h0, rsp}, {30'h0, io_line_pkg::RESP_OKAY});
      rd(io_line_pkg::OFF_LINE_CTRL_STATUS);
      chk(rd_v, io_line_pkg::LINE_MASK);
      // Set, clear and masked direct writes of the driven level
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         m = $random(seed);
         wr(io_line_pkg::OFF_LEVEL_SET, d);
         wr(io_line_pkg::OFF_LEVEL_CLEAR, m);
         lvl = (lvl | (d & io_line_pkg::LINE_MASK)) & ~m;
         wr(io_line_pkg::OFF_DIRECT_WRITE_ENABLE, m);
         wr(io_line_pkg::OFF_DIRECT_WRITE_DISABLE, ~m);
         d = $random(seed);
         wr(io_line_pkg::OFF_DRIVEN_LEVEL_STATUS, d);
         lvl = merge(lvl, d, m);
         rd(io_line_pkg::OFF_DRIVEN_LEVEL_STATUS);
         chk(rd_v, lvl);
         rd(io_line_pkg::OFF_DIRECT_WRITE_STATUS);
         chk(rd_v, m & io_line_pkg::LINE_MASK);
      end
      // Lowest byte lane only: other lanes keep their level
      strb <= 4'h1;
      wr(io_line_pkg::OFF_LEVEL_SET, 32'hffff_ffff);
      strb <= 4'hf;
      lvl = lvl | 32'h0000_00ff;
      rd(io_line_pkg::OFF_DRIVEN_LEVEL_STATUS);
      chk(rd_v, lvl);
      // Lower lines but 8 and 9 driven by us, upper lines held by pull-ups
      wr(io_line_pkg::OFF_DRIVE_ENABLE, 32'h0000_fcff);
      repeat (8) @(posedge clk);
      chk(pad_oe, 32'h0000_fcff);
      chk(pad_out, lvl);
      chk(pullup_on, io_line_pkg::LINE_MASK);
      rd(io_line_pkg::OFF_PIN_LEVEL);
      chk(rd_v, (lvl & 32'h0000_fcff) | 32'h0fff_0000);
      // Filter and mask bits: set then clear through the register pairs
      for (int k = 0; k < 2; k++) begin
         base = k ? io_line_pkg::OFF_CHANGE_IRQ_ENABLE
                  : io_line_pkg::OFF_FILTER_ENABLE;
         d = $random(seed);
         m = $random(seed);
         wr(base, d);
         wr(base + 8'h04, m);
         rd(base + 8'h08);
         chk(rd_v, d & ~m & io_line_pkg::LINE_MASK);
         wr(base + 8'h04, 32'hffff_ffff);
      end
      wr(io_line_pkg::OFF_FILTER_ENABLE, 32'h0000_0100);
      wr(io_line_pkg::OFF_CHANGE_IRQ_ENABLE, 32'h0010_0100);
      repeat (8) @(posedge clk);
      rd(io_line_pkg::OFF_CHANGE_IRQ_STATUS);
      // One-cycle pulse on a filtered, unmasked-in line
      @(posedge clk) ext_val[8] <= 1'b1;
      @(posedge clk) ext_val[8] <= 1'b0;
      repeat (8) @(posedge clk);
      chk({31'h0, change_irq}, 32'h1);
      rd(io_line_pkg::OFF_CHANGE_IRQ_STATUS);
      chk(rd_v, 32'h0000_0100);
      repeat (2) @(posedge clk);
      chk({31'h0, change_irq}, 32'h0);
      // Change on a masked-out line sets status but no irq
      ext_val[9] <= 1'b1;
      repeat (8) @(posedge clk);
      chk({31'h0, change_irq}, 32'h0);
      rd(io_line_pkg::OFF_CHANGE_IRQ_STATUS);
      chk(rd_v, 32'h0000_0200);
      // Peripheral takes line 20 and pulls it low
      periph_oe <= 32'h0010_0000;
      wr(io_line_pkg::OFF_LINE_CTRL_DISABLE, 32'h0010_0000);
      repeat (8) @(posedge clk);
      chk(periph_in & 32'h0010_0000, 32'h0000_0000);
      chk({31'h0, change_irq}, 32'h1);
      rd(io_line_pkg::OFF_CHANGE_IRQ_STATUS);
      chk(rd_v, 32'h0010_0000);
      // Controller clock off: levels frozen, no change seen
      rd(io_line_pkg::OFF_PIN_LEVEL);
      d = rd_v;
      ctrl_clk_en <= 1'b0;
      ext_val[9] <= 1'b0;
      repeat (8) @(posedge clk);
      rd(io_line_pkg::OFF_PIN_LEVEL);
      chk(rd_v, d);
      rd(io_line_pkg::OFF_CHANGE_IRQ_STATUS);
      chk(rd_v, 32'h0000_0000);
      complete_run();
   end
endmodule : test_io_line_input_and_change_irq
